// [rtl/xmd_decode.v]
// Memory-space decode: data-move routing, code routing, pointers, bus pins.
// Assumes the core issues one request at a time and waits for done.
`timescale 1ns/1ps
`default_nettype none
`include "xmd_defines.vh"
module xmd_decode (
	input wire clk,
	input wire nrst,
	input wire onchip_xram_enable,
	input wire [2:0] stretch_sel,
	input wire wait_enable,
	input wire external_access_pin,
	input wire wait_pin_in,
	input wire dm_req,
	input wire dm_write,
	input wire dm_use_ptr,
	input wire [15:0] dm_addr,
	input wire [7:0] dm_wdata,
	input wire code_req,
	input wire [15:0] code_addr,
	input wire [7:0] rom_rdata,
	input wire [7:0] p0_in,
	input wire [7:0] p0_gpio_out,
	input wire ptr_op,
	input wire [7:0] ptr_opcode,
	input wire pointer_select,
	input wire ptr_load,
	input wire ptr_load_high,
	input wire [7:0] ptr_load_data,
	input wire sp_req,
	input wire sp_write,
	input wire sp_direct,
	input wire [7:0] sp_addr,
	input wire [7:0] sp_wdata,
	output reg dm_done_ff,
	output reg [7:0] dm_rdata_ff,
	output reg code_done_ff,
	output reg [7:0] code_rdata_ff,
	output reg [14:0] rom_addr_ff,
	output reg [15:0] data_pointer_ff,
	output reg [7:0] sp_rdata_ff,
	output reg sp_sfr_sel_ff,
	output reg [7:0] p0_out_ff,
	output reg p0_oe_ff,
	output reg [7:0] p2_out_ff,
	output reg p2_oe_ff,
	output reg addr_latch_ff,
	output reg program_strobe_n_ff,
	output reg read_strobe_n_ff,
	output reg write_strobe_n_ff,
	output reg wait_pin_oe_ff
);
	// ****************************************************************
	// Local state and helpers
	// ****************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_XRAM = 3'h1;
	localparam ST_ADDR = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_CODE = 3'h4;
	localparam ST_ROM = 3'h5;
	localparam ST_END = 3'h6;

	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [1:0] phase_ff;
	reg [3:0] mc_ff;
	reg [3:0] mc_len_ff;
	reg is_code_ff;
	reg wr_ff;
	reg [15:0] addr_ff;
	reg [7:0] wdata_ff;
	reg [15:0] ptr0_ff;
	reg [15:0] ptr1_ff;
	reg wait_s1_ff;
	reg wait_s2_ff;
	reg ea_s1_ff;
	reg ea_s2_ff;
	reg [7:0] pad_s1_ff;
	reg [7:0] pad_s2_ff;
	reg xram_we;
	wire [7:0] xram_rdata;
	reg sp_we;
	reg sp_pend_ff;
	wire [7:0] scratch_rdata;

	// Address falls into the on-chip data SRAM window while enabled.
	function is_xram;
		input en;
		input [15:0] a;
		begin
			is_xram = en && (a <= `XMD_XRAM_TOP);
		end
	endfunction

	// Machine-cycle count for a given stretch setting, two plus the setting, two to nine.
	function [3:0] mc_count;
		input [2:0] s;
		begin
			mc_count = `XMD_MIN_MC + {1'b0, s};
		end
	endfunction

	wire mc_end = (phase_ff == `XMD_CLK_PER_MC);
	wire code_internal = ea_s2_ff && (code_addr <= `XMD_ROM_TOP);
	wire wait_hold = wait_enable && wait_s2_ff;
	// Routing must use the address that is really driven, pointer or immediate.
	wire [15:0] dm_eff_addr = dm_use_ptr ? data_pointer_ff : dm_addr;
	wire sp_sfr_hit = sp_direct && (sp_addr >= `XMD_SFR_BASE);

	// ****************************************************************
	// On-chip data store, reached only by data-move requests
	// ****************************************************************
	// Only the data-move path drives this store; code fetches never do.
	xmd_sram u_xram (
		.clk(clk),
		.we(xram_we),
		.addr(addr_ff[`XMD_XRAM_AW-1:0]),
		.wdata(wdata_ff),
		.rdata(xram_rdata)
	);

	// Write strobe to the on-chip store in its access cycle.
	always @* begin
		xram_we = (state_ff == ST_XRAM) && wr_ff && (phase_ff == 2'h0);
	end

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// Wait request, Port 0 read data and the access pin come from outside the domain.
	// The access pin is not reset, so its level is already valid at the first fetch.
	always @(posedge clk) begin
		ea_s1_ff <= external_access_pin;
		ea_s2_ff <= ea_s1_ff;
		if (!nrst) begin
			wait_s1_ff <= 1'b0;
			wait_s2_ff <= 1'b0;
			pad_s1_ff <= 8'h00;
			pad_s2_ff <= 8'h00;
		end else begin
			wait_s1_ff <= wait_pin_in;
			wait_s2_ff <= wait_s1_ff;
			pad_s1_ff <= p0_in;
			pad_s2_ff <= pad_s1_ff;
		end
	end

	// ****************************************************************
	// Access sequencer
	// ****************************************************************
	// Chooses the next access phase; bus phases change at machine-cycle boundaries, on-chip phases after two clocks.
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (dm_req) begin
					nxt_state = is_xram(onchip_xram_enable, dm_eff_addr) ? ST_XRAM : ST_ADDR;
				end else if (code_req) begin
					nxt_state = code_internal ? ST_ROM : ST_ADDR;
				end
			end
			ST_XRAM: nxt_state = (phase_ff == 2'h1) ? ST_END : ST_XRAM;
			ST_ROM: nxt_state = (phase_ff == 2'h1) ? ST_END : ST_ROM;
			ST_ADDR: nxt_state = mc_end ? (is_code_ff ? ST_CODE : ST_DATA) : ST_ADDR;
			ST_CODE: nxt_state = mc_end ? ST_END : ST_CODE;
			ST_DATA: begin
				if (mc_end && (mc_ff >= mc_len_ff - 4'h1) && !wait_hold) begin
					nxt_state = ST_END;
				end
			end
			ST_END: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Registers the request, counts clocks and machine cycles.
	always @(posedge clk) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
			phase_ff <= 2'h0;
			mc_ff <= 4'h0;
			mc_len_ff <= `XMD_MIN_MC;
			is_code_ff <= 1'b0;
			wr_ff <= 1'b0;
			addr_ff <= 16'h0000;
			wdata_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == ST_IDLE) begin
				phase_ff <= 2'h0;
				mc_ff <= 4'h0;
				mc_len_ff <= mc_count(stretch_sel);
				is_code_ff <= !dm_req;
				wr_ff <= dm_req && dm_write;
				addr_ff <= dm_req ? dm_eff_addr : code_addr;
				wdata_ff <= dm_wdata;
			end else begin
				phase_ff <= phase_ff + 2'h1;
				if (mc_end && !(state_ff == ST_DATA && wait_hold)) begin
					mc_ff <= mc_ff + 4'h1;
				end
			end
		end
	end

	// ****************************************************************
	// Bus pins and answers
	// ****************************************************************
	// Drives Port 0, Port 2 and strobes; on-chip accesses leave them idle.
	always @(posedge clk) begin
		if (!nrst) begin
			p0_out_ff <= 8'hFF;
			p0_oe_ff <= 1'b0;
			p2_out_ff <= 8'hFF;
			p2_oe_ff <= 1'b0;
			addr_latch_ff <= 1'b0;
			program_strobe_n_ff <= 1'b1;
			read_strobe_n_ff <= 1'b1;
			write_strobe_n_ff <= 1'b1;
			wait_pin_oe_ff <= 1'b0;
			dm_done_ff <= 1'b0;
			dm_rdata_ff <= 8'h00;
			code_done_ff <= 1'b0;
			code_rdata_ff <= 8'h00;
			rom_addr_ff <= 15'h0000;
		end else begin
			wait_pin_oe_ff <= 1'b0;
			dm_done_ff <= 1'b0;
			code_done_ff <= 1'b0;
			addr_latch_ff <= (state_ff == ST_ADDR) && (phase_ff < 2'h2);
			case (state_ff)
				ST_ADDR: begin
					p0_out_ff <= addr_ff[7:0];
					p0_oe_ff <= 1'b1;
					p2_out_ff <= addr_ff[15:8];
					p2_oe_ff <= 1'b1;
				end
				ST_DATA: begin
					p0_out_ff <= wdata_ff;
					p0_oe_ff <= wr_ff;
					read_strobe_n_ff <= wr_ff;
					write_strobe_n_ff <= !wr_ff;
				end
				ST_CODE: begin
					p0_oe_ff <= 1'b0;
					program_strobe_n_ff <= 1'b0;
				end
				ST_ROM: begin
					rom_addr_ff <= addr_ff[14:0];
				end
				ST_END: begin
					read_strobe_n_ff <= 1'b1;
					write_strobe_n_ff <= 1'b1;
					program_strobe_n_ff <= 1'b1;
					p2_oe_ff <= 1'b0;
					if (is_code_ff) begin
						code_done_ff <= 1'b1;
						code_rdata_ff <= p2_oe_ff ? pad_s2_ff : rom_rdata;
					end else begin
						dm_done_ff <= 1'b1;
						dm_rdata_ff <= p2_oe_ff ? pad_s2_ff : xram_rdata;
					end
					p0_out_ff <= p0_gpio_out;
					p0_oe_ff <= 1'b0;
				end
				ST_IDLE: begin
					p0_out_ff <= p0_gpio_out;
					p0_oe_ff <= 1'b0;
				end
				default: begin
					p0_oe_ff <= p0_oe_ff;
				end
			endcase
		end
	end

	// ****************************************************************
	// Dual data pointers
	// ****************************************************************
	// Loads, decrements and selects the active pointer pair.
	always @(posedge clk) begin
		if (!nrst) begin
			ptr0_ff <= 16'h0000;
			ptr1_ff <= 16'h0000;
			data_pointer_ff <= 16'h0000;
		end else begin
			if (ptr_load && !pointer_select) begin
				if (ptr_load_high) ptr0_ff[15:8] <= ptr_load_data;
				else ptr0_ff[7:0] <= ptr_load_data;
			end else if (ptr_op && ptr_opcode == `XMD_OP_DEC_PTR && !pointer_select) begin
				ptr0_ff <= ptr0_ff - 16'h0001;
			end
			if (ptr_load && pointer_select) begin
				if (ptr_load_high) ptr1_ff[15:8] <= ptr_load_data;
				else ptr1_ff[7:0] <= ptr_load_data;
			end else if (ptr_op && ptr_opcode == `XMD_OP_DEC_PTR && pointer_select) begin
				ptr1_ff <= ptr1_ff - 16'h0001;
			end
			data_pointer_ff <= pointer_select ? ptr1_ff : ptr0_ff;
		end
	end

	// ****************************************************************
	// Scratchpad store, separate from the data SRAM
	// ****************************************************************
	// Writes reach the scratch store only outside function-register space.
	always @* begin
		sp_we = sp_req && sp_write && !sp_sfr_hit;
	end

	// A store of its own, so no data-move address can ever alias it.
	xmd_sram u_scratch (
		.clk(clk),
		.we(sp_we),
		.addr({2'b00, sp_addr}),
		.wdata(sp_wdata),
		.rdata(scratch_rdata)
	);

	// Upper half is function-register space when addressed directly.
	always @(posedge clk) begin
		if (!nrst) begin
			sp_rdata_ff <= 8'h00;
			sp_sfr_sel_ff <= 1'b0;
			sp_pend_ff <= 1'b0;
		end else begin
			sp_sfr_sel_ff <= sp_req && sp_sfr_hit;
			sp_pend_ff <= sp_req && !sp_sfr_hit;
			if (sp_pend_ff) begin
				sp_rdata_ff <= scratch_rdata;
			end
		end
	end
endmodule // xmd_decode
`default_nettype wire

// [rtl/xmd_defines.vh]
// Constants for the memory-space decode and access routing block.
// Assumes a 20 MHz core clock with four clocks per machine cycle.
`ifndef XMD_DEFINES_VH
`define XMD_DEFINES_VH
`define XMD_XRAM_TOP 16'h03FF
`define XMD_XRAM_AW 10
`define XMD_ROM_TOP 16'h7FFF
`define XMD_CLK_PER_MC 2'h3
`define XMD_MIN_MC 4'h2
`define XMD_MAX_MC 4'h9
`define XMD_OP_DEC_PTR 8'hA5
`define XMD_SFR_BASE 8'h80
`endif

// [rtl/xmd_sram.v]
// Single-port 1 KB by 8 data store with registered read data.
// Assumes one clock; write and read share the address.
`timescale 1ns/1ps
`default_nettype none
`include "xmd_defines.vh"
module xmd_sram (
	input wire clk,
	input wire we,
	input wire [`XMD_XRAM_AW-1:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata
);
	reg [7:0] mem [0:(1<<`XMD_XRAM_AW)-1];

	// Writes store, reads return the word one clock later.
	always @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule // xmd_sram
`default_nettype wire

// [tb/xmd_decode_asserts.sv]
// Pin-level checker for the memory decode block.
// Assumes the synchronous active-low reset nrst.
`timescale 1ns/1ps
`default_nettype none
// ********
// Checker
// ********
module xmd_decode_asserts (
	input wire clk,
	input wire nrst,
	input wire onchip_xram_enable,
	input wire external_access_pin,
	input wire dm_req,
	input wire dm_use_ptr,
	input wire [15:0] dm_addr,
	input wire p0_oe_ff,
	input wire p2_oe_ff,
	input wire [7:0] p2_out_ff,
	input wire addr_latch_ff,
	input wire program_strobe_n_ff,
	input wire read_strobe_n_ff,
	input wire write_strobe_n_ff,
	input wire wait_pin_oe_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// The bus is quiet when no strobe, latch or port driver is active.
	wire quiet = read_strobe_n_ff && write_strobe_n_ff && program_strobe_n_ff
		&& !p0_oe_ff && !p2_oe_ff && !addr_latch_ff;
	chk_reset_idle: assert property ($rose(nrst) |-> quiet)
		else $error("bus active after reset");
	chk_wait_input: assert property (!wait_pin_oe_ff)
		else $error("wait pin driven");
	chk_read_release: assert property (
		!read_strobe_n_ff || !program_strobe_n_ff |-> !p0_oe_ff)
		else $error("port 0 driven during read");
	chk_write_drive: assert property (!write_strobe_n_ff |-> p0_oe_ff && p2_oe_ff)
		else $error("ports not driven during write");
	chk_latch_drive: assert property (addr_latch_ff |-> p0_oe_ff && p2_oe_ff)
		else $error("ports not driven with latch");
	chk_one_strobe: assert property ($onehot0({!read_strobe_n_ff,
		!write_strobe_n_ff, !program_strobe_n_ff}))
		else $error("two strobes active");
	chk_code_route: assert property ($fell(program_strobe_n_ff) |-> p2_oe_ff
		&& (p2_out_ff[7] || !external_access_pin))
		else $error("internal code fetch on bus");
	chk_onchip_quiet: assert property (dm_req && onchip_xram_enable && !dm_use_ptr
		&& dm_addr < 16'h0400 && quiet |=> quiet [*4])
		else $error("on-chip access touched bus");
	chk_ext_route: assert property (dm_req && !dm_use_ptr && quiet
		&& (!onchip_xram_enable || dm_addr > 16'h03FF) |-> ##[1:6] addr_latch_ff)
		else $error("external access not started");
	cov_onchip: cover property (dm_req && onchip_xram_enable && dm_addr < 16'h0400);
	cov_code: cover property ($fell(program_strobe_n_ff));
	cov_write: cover property ($fell(write_strobe_n_ff));
endmodule // xmd_decode_asserts
bind xmd_decode xmd_decode_asserts u_chk (.*);
`default_nettype wire

// [tb/xmd_decode_bench.sv]
// Bench for the memory decode block: access tasks and expected values.
// Assumes the external memory model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
// ********
// Bench
// ********
module xmd_decode_bench;
	logic clk = 0, nrst = 0, onchip_xram_enable = 0, wait_enable = 0, slow = 0;
	logic external_access_pin = 1, dm_req = 0, dm_write = 0, dm_use_ptr = 0;
	logic code_req = 0, ptr_op = 0, pointer_select = 0, ptr_load = 0;
	logic ptr_load_high = 0, sp_req = 0, sp_write = 0, sp_direct = 0;
	logic [2:0] stretch_sel = 0;
	logic [15:0] dm_addr = 0, code_addr = 0;
	logic [7:0] dm_wdata = 0, ptr_opcode = 0, ptr_load_data = 0, sp_addr = 0;
	logic [7:0] sp_wdata = 0, p0_gpio_out = 8'hFF, q, drv;
	logic sfr_q;
	wire [7:0] rom_rdata, p0_in, dm_rdata_ff, code_rdata_ff, sp_rdata_ff, p0_out_ff, p2_out_ff;
	wire wait_pin_in, dm_done_ff, code_done_ff, sp_sfr_sel_ff, p0_oe_ff, p2_oe_ff;
	wire addr_latch_ff, program_strobe_n_ff, read_strobe_n_ff, write_strobe_n_ff;
	wire wait_pin_oe_ff;
	wire [14:0] rom_addr_ff;
	wire [15:0] data_pointer_ff;
	int fails = 0, n_checks = 0, cyc = 0, n, n0;
	// Port 0 level and internal ROM contents.
	assign p0_in = p0_oe_ff ? p0_out_ff : drv;
	assign rom_rdata = rom_addr_ff[7:0] ^ 8'h3C;
	xmd_decode u_dut (.*);
	xmd_ext_mem u_mem (.clk(clk), .ale(addr_latch_ff), .wr_n(write_strobe_n_ff),
		.rd_n(read_strobe_n_ff), .ps_n(program_strobe_n_ff), .slow(slow),
		.bus(p0_in), .drv(drv), .wt(wait_pin_in));
	// Clock and hang limit.
	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (++cyc == 5000) begin
			fails++;
			summarize;
		end
	end
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(string s, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// One request; n counts edges from take to done, q holds the answer.
	task acc(bit c, bit w, logic [15:0] a, logic [7:0] d);
		@(posedge clk) #1;
		if (c) begin
			code_req = 1;
			code_addr = a;
		end else begin
			dm_req = 1;
			dm_write = w;
			dm_addr = a;
			dm_wdata = d;
		end
		@(posedge clk) #1;
		dm_req = 0;
		code_req = 0;
		n = 0;
		while (!(dm_done_ff === 1 || code_done_ff === 1) && n < 200) begin
			@(posedge clk) #1;
			n++;
		end
		q = c ? code_rdata_ff : dm_rdata_ff;
	endtask
	task sp(bit w, bit dir, logic [7:0] a, logic [7:0] d);
		@(posedge clk) #1;
		sp_req = 1;
		sp_write = w;
		sp_direct = dir;
		sp_addr = a;
		sp_wdata = d;
		@(posedge clk) #1;
		sp_req = 0;
		sfr_q = sp_sfr_sel_ff;
		@(posedge clk) #1;
	endtask
	task pl(logic [15:0] v);
		@(posedge clk) #1;
		ptr_load = 1;
		ptr_load_high = 1;
		ptr_load_data = v[15:8];
		@(posedge clk) #1;
		ptr_load_high = 0;
		ptr_load_data = v[7:0];
		@(posedge clk) #1;
		ptr_load = 0;
	endtask
	// Main sequence of scenarios.
	initial begin
		repeat (8) @(posedge clk);
		#1 nrst = 1;
		chk("pointer", 16'h0000, data_pointer_ff);
		acc(0, 1, 16'h03FF, 8'h5A);
		onchip_xram_enable = 1;
		acc(0, 1, 16'h03FF, 8'hC3);
		acc(0, 0, 16'h03FF, 0);
		n0 = n;
		chk("onchip rd", 8'hC3, q);
		chk("onchip time", 16'h0003, 16'(n0));
		acc(0, 1, 16'h0400, 8'h66);
		acc(0, 0, 16'h0400, 0);
		chk("ext rd", 8'h66, q);
		chk("ext time", 16'(n0 + 6), 16'(n));
		onchip_xram_enable = 0;
		acc(0, 0, 16'h03FF, 0);
		chk("hidden rd", 8'h5A, q);
		for (int s = 1; s < 8; s++) begin
			stretch_sel = s[2:0];
			acc(0, 0, 16'h2001, 0);
			chk("stretch", 16'(n0 + 6 + 4 * s), 16'(n));
		end
		wait_enable = 1;
		slow = 1;
		acc(0, 0, 16'h2001, 0);
		chk("wait", 1, n > n0 + 34);
		chk("wait rd", 8'h01, q);
		wait_enable = 0;
		slow = 0;
		stretch_sel = 0;
		acc(1, 0, 16'h1234, 0);
		chk("rom rd", 8'h08, q);
		chk("rom time", 16'(n0), 16'(n));
		acc(1, 0, 16'h8000, 0);
		chk("xrom rd", 8'h66, q);
		chk("xrom time", 16'(n0 + 6), 16'(n));
		external_access_pin = 0;
		repeat (2) @(posedge clk);
		acc(1, 0, 16'h1234, 0);
		chk("forced ext", 8'h34, q);
		external_access_pin = 1;
		pl(16'h0400);
		pointer_select = 1;
		pl(16'h0000);
		@(posedge clk) #1;
		ptr_op = 1;
		ptr_opcode = 8'hA5;
		@(posedge clk) #1;
		ptr_op = 0;
		repeat (2) @(posedge clk);
		chk("dec ptr", 16'hFFFF, data_pointer_ff);
		#1 pointer_select = 0;
		repeat (2) @(posedge clk);
		chk("sel ptr", 16'h0400, data_pointer_ff);
		#1 dm_use_ptr = 1;
		onchip_xram_enable = 1;
		acc(0, 0, 16'h0000, 0);
		chk("ptr rd", 8'h66, q);
		dm_use_ptr = 0;
		sp(1, 0, 8'h10, 8'h77);
		acc(0, 1, 16'h0010, 8'h11);
		sp(0, 0, 8'h10, 0);
		chk("scratch", 8'h77, sp_rdata_ff);
		acc(0, 0, 16'h0010, 0);
		chk("xram 10", 8'h11, q);
		sp(0, 1, 8'h90, 0);
		chk("sfr sel", 1, sfr_q);
		sp(0, 0, 8'h90, 0);
		chk("indirect", 0, sfr_q);
		summarize;
	end
endmodule // xmd_decode_bench
`default_nettype wire

// [tb/xmd_ext_mem.sv]
// External memory model on the multiplexed bus, 256 bytes by low address.
// Assumes the bench resolves port 0 from both drivers.
`timescale 1ns/1ps
`default_nettype none
// ********
// Model
// ********
module xmd_ext_mem (
	input wire logic clk,
	input wire logic ale,
	input wire logic wr_n,
	input wire logic rd_n,
	input wire logic ps_n,
	input wire logic slow,
	input wire logic [7:0] bus,
	output logic [7:0] drv,
	output logic wt
);
	logic [7:0] m [0:255];
	logic [7:0] a_ff;
	int w;
	// Each byte starts out holding its own address.
	initial begin
		for (int i = 0; i < 256; i++) m[i] = i[7:0];
		a_ff = 8'h00;
		drv = 8'h00;
		wt = 0;
		w = 0;
	end
	// Released data toggles so a stale byte is never read as valid.
	always @(posedge clk) begin
		if (ale) a_ff <= bus;
		if (!wr_n) m[a_ff] <= bus;
		drv <= (!rd_n || !ps_n) ? m[a_ff] : ~drv;
		wt <= slow && !rd_n && w < 8;
		w <= rd_n ? 0 : w + 1;
	end
endmodule // xmd_ext_mem
`default_nettype wire
